// ### uls_pkg.sv
//----------------------------------------------------------------------
// uls_pkg: shared constants of the line status block
//----------------------------------------------------------------------
// Summary of operation
// - bit 7 set when an errored character is queued
// - reading line status clears bit 7
// - non-FIFO: bit 6 when holding and shift empty
// - bit 6 low while any character pending
// - FIFO mode: bit 6 when FIFO, shift empty
// - non-FIFO: bit 5 set on holding-to-shift move
// - FIFO mode: bit 5 follows transmit FIFO empty
// - transmit request when bit 5 and enabled
// - bit 4 after line low one frame
// - one break character per break condition
// - break and bit 7 zero after reset
// - bit 3 framing error of top character
// - bit 2 parity error of top character
// - overrun sets bit 1, FIFO kept intact
// - bit 0 while any received character held
package uls_pkg;

    //------------------------------------------------------------------
    // register map, byte addresses
    //------------------------------------------------------------------
    localparam logic [11:0] ULS_OFF_LINE_STATUS = 12'h000;
    localparam logic [11:0] ULS_OFF_CTRL = 12'h004;

    //------------------------------------------------------------------
    // line status bit positions
    //------------------------------------------------------------------
    localparam int ULS_LS_DATA_READY = 0;
    localparam int ULS_LS_OVERRUN = 1;
    localparam int ULS_LS_PARITY = 2;
    localparam int ULS_LS_FRAMING = 3;
    localparam int ULS_LS_BREAK = 4;
    localparam int ULS_LS_THR_EMPTY = 5;
    localparam int ULS_LS_TX_EMPTY = 6;
    localparam int ULS_LS_FIFO_ERR = 7;

    //------------------------------------------------------------------
    // control register fields and reset values
    //------------------------------------------------------------------
    localparam int ULS_CTRL_FIFO_MODE = 0;
    localparam int ULS_CTRL_THRE_EN = 1;
    localparam int ULS_CTRL_FRAME_LSB = 4;
    localparam int ULS_CTRL_FRAME_MSB = 7;
    localparam logic [3:0] ULS_FRAME_BITS_RST = 4'ha;

    //------------------------------------------------------------------
    // receive tag queue: tag = {break, framing, parity}
    //------------------------------------------------------------------
    localparam int ULS_RX_DEPTH = 16;
    localparam int ULS_TAG_W = 3;
    localparam logic [4:0] ULS_RX_DEPTH_CNT = 5'h10;
    localparam logic [4:0] ULS_RX_HOLD_CNT = 5'h01;

endpackage : uls_pkg

// ### uls_break_det.sv
`timescale 1ns/1ps
module uls_break_det
    import uls_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic rx_line,
    input wire logic rx_bit_tick,
    input wire logic [3:0] frame_bits,
    output logic brk_pulse
);

    typedef struct packed {
        logic [3:0] cnt;
        logic done;
        logic pulse;
    } uls_brk_st_t;

    uls_brk_st_t st_ff;
    uls_brk_st_t nxt_st;

    // count low bit times; fire once, rearm only when the line goes high
    always_comb begin
        nxt_st = st_ff;
        nxt_st.pulse = 1'b0;
        if (rx_line) begin
            nxt_st.cnt = 4'h0;
            nxt_st.done = 1'b0;
        end else if (rx_bit_tick && !st_ff.done) begin
            if ((st_ff.cnt + 4'h1) >= frame_bits) begin
                nxt_st.done = 1'b1;
                nxt_st.pulse = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 4'h1;
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign brk_pulse = st_ff.pulse;

endmodule : uls_break_det

// ### uls_rx_tag_fifo.sv
`timescale 1ns/1ps
module uls_rx_tag_fifo
    import uls_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic fifo_mode,
    input wire logic push,
    input wire logic [ULS_TAG_W-1:0] push_tag,
    input wire logic pop,
    output logic [ULS_TAG_W-1:0] top_tag,
    output logic [4:0] count,
    output logic [4:0] err_count,
    output logic full,
    output logic overrun
);

    typedef struct packed {
        logic [ULS_RX_DEPTH-1:0][ULS_TAG_W-1:0] mem;
        logic [3:0] rd;
        logic [3:0] wr;
        logic [4:0] cnt;
        logic [4:0] errs;
        logic ovr;
    } uls_fifo_st_t;

    uls_fifo_st_t st_ff;
    uls_fifo_st_t nxt_st;
    logic do_push;
    logic do_pop;
    logic [4:0] cap;

    // outside FIFO mode the queue is a single holding slot
    assign cap = fifo_mode ? ULS_RX_DEPTH_CNT : ULS_RX_HOLD_CNT;
    assign full = (st_ff.cnt >= cap);
    assign do_pop = pop && (st_ff.cnt != 5'h0);
    assign do_push = push && (!full || do_pop);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ovr = push && !do_push;
        if (do_push) begin
            nxt_st.mem[st_ff.wr] = push_tag;
            nxt_st.wr = st_ff.wr + 4'h1;
        end
        if (do_pop) begin
            nxt_st.rd = st_ff.rd + 4'h1;
        end
        nxt_st.cnt = st_ff.cnt + {4'h0, do_push} - {4'h0, do_pop};
        nxt_st.errs = st_ff.errs + {4'h0, do_push && (push_tag != 3'h0)}
            - {4'h0, do_pop && (st_ff.mem[st_ff.rd] != 3'h0)};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // empty queue shows clean flags
    assign top_tag = (st_ff.cnt != 5'h0) ? st_ff.mem[st_ff.rd] : 3'h0;
    assign count = st_ff.cnt;
    assign err_count = st_ff.errs;
    assign overrun = st_ff.ovr;

endmodule : uls_rx_tag_fifo

// ### uls_line_status.sv
`timescale 1ns/1ps
module uls_line_status
    import uls_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // transmit path
    input wire logic tx_hold_load,
    input wire logic tx_hold_to_shift,
    input wire logic tx_shift_busy,
    input wire logic [4:0] tx_fifo_count,
    // receive path
    input wire logic rx_line,
    input wire logic rx_bit_tick,
    input wire logic rx_char_done,
    input wire logic rx_char_parity_err,
    input wire logic rx_char_frame_err,
    input wire logic rx_pop,
    output logic rx_full,
    // channel controls and request
    output logic fifo_mode,
    output logic tx_irq
);

    //------------------------------------------------------------------
    // state
    //------------------------------------------------------------------
    typedef struct packed {
        logic fifo_mode;
        logic thre_en;
        logic [3:0] frame_bits;
        logic thre;
        logic temt;
        logic ovr;
        logic fifo_err;
        logic irq;
        logic [31:0] rdata;
    } uls_top_st_t;

    uls_top_st_t st_ff;
    uls_top_st_t nxt_st;

    //------------------------------------------------------------------
    // bus decode
    //------------------------------------------------------------------
    logic setup_ph;
    logic access_ph;
    logic hit_status;
    logic hit_ctrl;
    logic mapped;
    logic wr_done;
    logic rd_done;
    logic status_rd_done;

    // address decode, shared by setup capture and access completion
    always_comb begin
        hit_status = 1'b0;
        hit_ctrl = 1'b0;
        if (paddr == ULS_OFF_LINE_STATUS) begin
            hit_status = 1'b1;
        end else if (paddr == ULS_OFF_CTRL) begin
            hit_ctrl = 1'b1;
        end
    end

    // phases of an apb transfer; zero wait states
    assign mapped = hit_status || hit_ctrl;
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign wr_done = access_ph && pwrite && mapped;
    assign rd_done = access_ph && !pwrite;
    assign status_rd_done = rd_done && hit_status;

    // handshake outputs are combinational; unmapped access errors out
    assign pready = 1'b1;
    assign pslverr = access_ph && !mapped;

    //------------------------------------------------------------------
    // receive side: break detector and tag queue
    //------------------------------------------------------------------
    logic brk_pulse;
    logic rx_push;
    logic [ULS_TAG_W-1:0] rx_tag;
    logic [ULS_TAG_W-1:0] top_tag;
    logic [4:0] rx_count;
    logic [4:0] rx_errs;
    logic rx_ovr;
    logic err_push;

    uls_break_det u_brk (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .rx_line(rx_line),
        .rx_bit_tick(rx_bit_tick),
        .frame_bits(st_ff.frame_bits),
        .brk_pulse(brk_pulse)
    );

    assign rx_push = rx_char_done || brk_pulse;
    assign rx_tag = {brk_pulse, rx_char_frame_err, rx_char_parity_err};
    // an errored character that really enters the queue
    assign err_push = rx_push && (rx_tag != 3'h0) && (!rx_full || (rx_pop && rx_count != 5'h0));

    uls_rx_tag_fifo u_rxq (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .fifo_mode(st_ff.fifo_mode),
        .push(rx_push),
        .push_tag(rx_tag),
        .pop(rx_pop),
        .top_tag(top_tag),
        .count(rx_count),
        .err_count(rx_errs),
        .full(rx_full),
        .overrun(rx_ovr)
    );

    //------------------------------------------------------------------
    // line status byte
    //------------------------------------------------------------------
    logic [7:0] status;

    // assembled from registered flags and the top of the queue
    always_comb begin
        status = 8'h00;
        status[ULS_LS_DATA_READY] = (rx_count != 5'h0);
        status[ULS_LS_OVERRUN] = st_ff.ovr;
        status[ULS_LS_PARITY] = top_tag[0];
        status[ULS_LS_FRAMING] = top_tag[1];
        status[ULS_LS_BREAK] = top_tag[2];
        status[ULS_LS_THR_EMPTY] = st_ff.thre;
        status[ULS_LS_TX_EMPTY] = st_ff.temt;
        status[ULS_LS_FIFO_ERR] = st_ff.fifo_err;
    end

    //------------------------------------------------------------------
    // next state
    //------------------------------------------------------------------
    logic tx_fifo_empty;
    logic nxt_hold_empty;

    assign tx_fifo_empty = (tx_fifo_count == 5'h00);

    always_comb begin
        nxt_st = st_ff;
        nxt_hold_empty = st_ff.thre;

        // control register write; other bits of the word are ignored
        if (wr_done && hit_ctrl) begin
            nxt_st.fifo_mode = pwdata[ULS_CTRL_FIFO_MODE];
            nxt_st.thre_en = pwdata[ULS_CTRL_THRE_EN];
            nxt_st.frame_bits = pwdata[ULS_CTRL_FRAME_MSB:ULS_CTRL_FRAME_LSB];
        end

        // read data captured in setup so prdata comes from a flop
        if (setup_ph && !pwrite) begin
            if (hit_status) begin
                nxt_st.rdata = {24'h000000, status};
            end else if (hit_ctrl) begin
                nxt_st.rdata = {24'h000000, st_ff.frame_bits, 2'b00,
                    st_ff.thre_en, st_ff.fifo_mode};
            end else begin
                nxt_st.rdata = 32'h00000000;
            end
        end

        // holding empty: load beats transfer when both arrive together
        if (st_ff.fifo_mode) begin
            nxt_hold_empty = tx_fifo_empty && !tx_hold_load;
        end else if (tx_hold_load) begin
            nxt_hold_empty = 1'b0;
        end else if (tx_hold_to_shift) begin
            nxt_hold_empty = 1'b1;
        end
        nxt_st.thre = nxt_hold_empty;

        // transmitter empty needs the shift register idle as well
        if (st_ff.fifo_mode) begin
            nxt_st.temt = tx_fifo_empty && !tx_hold_load && !tx_shift_busy;
        end else begin
            nxt_st.temt = nxt_hold_empty && !tx_shift_busy && !tx_hold_to_shift;
        end

        // clear only what the host was shown; a new event always wins
        // sticky overrun flag
        nxt_st.ovr = (st_ff.ovr && !(status_rd_done && st_ff.rdata[ULS_LS_OVERRUN]))
            || rx_ovr;

        // bit 7 also drops once no errored entry is left in the queue
        if (err_push) begin
            nxt_st.fifo_err = 1'b1;
        end else if (status_rd_done && st_ff.rdata[ULS_LS_FIFO_ERR]) begin
            nxt_st.fifo_err = 1'b0;
        end else if (rx_errs == 5'h00) begin
            nxt_st.fifo_err = 1'b0;
        end

        nxt_st.irq = nxt_hold_empty && nxt_st.thre_en;
    end

    //------------------------------------------------------------------
    // state register
    //------------------------------------------------------------------
    // error flags zero at reset, both transmit empty flags set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff.fifo_mode <= 1'b0;
            st_ff.thre_en <= 1'b0;
            st_ff.frame_bits <= ULS_FRAME_BITS_RST;
            st_ff.thre <= 1'b1;
            st_ff.temt <= 1'b1;
            st_ff.ovr <= 1'b0;
            st_ff.fifo_err <= 1'b0;
            st_ff.irq <= 1'b0;
            st_ff.rdata <= 32'h00000000;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    //------------------------------------------------------------------
    // outputs
    //------------------------------------------------------------------
    assign prdata = st_ff.rdata;
    assign fifo_mode = st_ff.fifo_mode;
    assign tx_irq = st_ff.irq;

endmodule : uls_line_status

// ### uls_line_status_properties.sv
`timescale 1ns/1ps
//----------------------------------------------------------------------
// checker of the line status block ports
//----------------------------------------------------------------------
module uls_line_status_properties
    import uls_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tx_hold_load,
    input wire logic [4:0] tx_fifo_count,
    input wire logic rx_char_done,
    input wire logic rx_pop,
    input wire logic rx_full,
    input wire logic fifo_mode,
    input wire logic tx_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // status read setup, and write accesses to any address that may flip the mode
    wire st_rd = psel && !penable && !pwrite && ce && paddr == ULS_OFF_LINE_STATUS;
    wire wr_acc = psel && penable && pwrite;
    wire mapped = paddr == ULS_OFF_LINE_STATUS || paddr == ULS_OFF_CTRL;
    ready_always_a: assert property (pready)
        else $error("pready low");
    unmapped_err_a: assert property (psel && penable && !mapped |-> pslverr)
        else $error("no error on unmapped access");
    mapped_ok_a: assert property (psel && penable && mapped |-> !pslverr)
        else $error("error on mapped access");
    status_upper_a: assert property (st_rd |=> prdata[31:8] == 24'h0)
        else $error("status upper bits set");
    ready_bit_a: assert property (st_rd && rx_full |=> prdata[ULS_LS_DATA_READY])
        else $error("data ready low with queue full");
    load_irq_a: assert property (ce && tx_hold_load |=> !tx_irq)
        else $error("request after holding load");
    fifo_irq_a: assert property (ce && fifo_mode && !wr_acc && tx_fifo_count != 5'h0
        |=> !tx_irq)
        else $error("request with transmit fifo occupied");
    hold_full_a: assert property (ce && !fifo_mode && !wr_acc && rx_char_done && !rx_pop
        |=> rx_full)
        else $error("holding entry not full after push");
    freeze_irq_a: assert property (!ce |=> $stable(tx_irq) && $stable(fifo_mode))
        else $error("state moved with clock enable low");
    cover property (st_rd);
    cover property ($rose(tx_irq));
    cover property ($rose(rx_full));
endmodule : uls_line_status_properties

bind uls_line_status uls_line_status_properties chk (.*);

// ### uls_apb_host.sv
`timescale 1ns/1ps
//----------------------------------------------------------------------
// host model: one apb transfer per go pulse
//----------------------------------------------------------------------
module uls_apb_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic wr,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic done,
    output logic [31:0] rdata,
    output logic err
);
    // request held until pready seen high; data inverted on release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psel <= 1'b0;
            penable <= 1'b0;
            pwrite <= 1'b0;
            paddr <= 12'h000;
            pwdata <= 32'h0;
            done <= 1'b0;
            rdata <= 32'h0;
            err <= 1'b0;
        end else begin
            done <= 1'b0;
            if (psel && penable && pready) begin
                psel <= 1'b0;
                penable <= 1'b0;
                pwdata <= ~pwdata;
                rdata <= prdata;
                err <= pslverr;
                done <= 1'b1;
            end else if (psel) begin
                penable <= 1'b1;
            end else if (go) begin
                psel <= 1'b1;
                pwrite <= wr;
                paddr <= addr;
                pwdata <= wdata;
            end
        end
    end
endmodule : uls_apb_host

// ### uls_line_status_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module uls_line_status_tb
    import uls_pkg::*;
;
    logic pclk = 0, presetn = 0, ce = 1, go = 0, wr = 0, tx_hold_load = 0;
    logic tx_hold_to_shift = 0, tx_shift_busy = 0, rx_line = 1, rx_bit_tick = 0;
    logic rx_char_done = 0, rx_char_parity_err = 0, rx_char_frame_err = 0, rx_pop = 0;
    logic [11:0] addr = 0;
    logic [31:0] wdata = 0;
    logic [4:0] tx_fifo_count = 0;
    logic psel, penable, pwrite, pready, pslverr, done, err, rx_full, fifo_mode, tx_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    int n_mismatch = 0, check_count = 0, i, n;
    uls_line_status uut (.*);
    uls_apb_host host (.*);
    always #4 pclk = ~pclk;
    // expected status byte and control word
    function automatic logic [7:0] sv(input logic fe, te, th, bk, fr, pa, ov, dr);
        return {fe, te, th, bk, fr, pa, ov, dr};
    endfunction : sv
    function automatic logic [31:0] ctl(input logic fi, en, input logic [3:0] fl);
        return {24'h0, fl, 2'b00, en, fi};
    endfunction : ctl
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test
    // bounded wait: a lost handshake ends the run
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        go <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge pclk);
        go <= 1'b0;
        for (i = 0; i < 20 && done !== 1'b1; i++) @(negedge pclk);
        if (done !== 1'b1) begin
            n_mismatch++;
            stop_test();
        end
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdata, e)
    endtask : rd
    task automatic st(input logic [7:0] e);
        rd(ULS_OFF_LINE_STATUS, {24'h0, e});
    endtask : st
    // one cycle of {load, move, pop, char done}, shift busy held after
    task automatic pl(input logic [3:0] m, input logic b, input logic p = 0, f = 0);
        @(posedge pclk);
        {tx_hold_load, tx_hold_to_shift, rx_pop, rx_char_done} <= m;
        {rx_char_parity_err, rx_char_frame_err} <= {p, f};
        tx_shift_busy <= b;
        @(posedge pclk);
        {tx_hold_load, tx_hold_to_shift, rx_pop, rx_char_done} <= 4'h0;
    endtask : pl
    initial begin
        void'($urandom(32'h2a0f6e0f));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        st(sv(0, 1, 1, 0, 0, 0, 0, 0));
        rd(ULS_OFF_CTRL, ctl(0, 0, 4'ha));
        rd(12'h008, 32'h0);
        `CHK(err, 1'b1)
        $display("test reset done");
        apb(1'b1, ULS_OFF_CTRL, ctl(0, 1, 4'h4));
        `CHK(tx_irq, 1'b1)
        pl(4'b1000, 0);
        st(sv(0, 0, 0, 0, 0, 0, 0, 0));
        `CHK(tx_irq, 1'b0)
        pl(4'b0100, 1);
        st(sv(0, 0, 1, 0, 0, 0, 0, 0));
        pl(4'b0000, 0);
        st(sv(0, 1, 1, 0, 0, 0, 0, 0));
        pl(4'b1100, 0);
        st(sv(0, 0, 0, 0, 0, 0, 0, 0));
        pl(4'b0100, 0);
        @(posedge pclk) ce <= 1'b0;
        pl(4'b1000, 0);
        @(posedge pclk) ce <= 1'b1;
        st(sv(0, 1, 1, 0, 0, 0, 0, 0));
        $display("test holding done");
        `CHK(fifo_mode, 1'b0)
        apb(1'b1, ULS_OFF_CTRL, ctl(1, 1, 4'h4));
        `CHK(fifo_mode, 1'b1)
        for (int k = 0; k < 4; k++) begin
            n = $urandom_range(16, 1);
            @(posedge pclk) tx_fifo_count <= n[4:0];
            st(sv(0, 0, 0, 0, 0, 0, 0, 0));
            `CHK(tx_irq, 1'b0)
        end
        @(posedge pclk) tx_fifo_count <= 5'h0;
        pl(4'b0000, 1);
        st(sv(0, 0, 1, 0, 0, 0, 0, 0));
        pl(4'b0000, 0);
        st(sv(0, 1, 1, 0, 0, 0, 0, 0));
        $display("test fifo transmit done");
        n = $urandom_range(5, 2);
        pl(4'b0001, 0, 1, 0);
        for (int k = 1; k < n; k++) pl(4'b0001, 0);
        st(sv(1, 1, 1, 0, 0, 1, 0, 1));
        st(sv(0, 1, 1, 0, 0, 1, 0, 1));
        pl(4'b0010, 0);
        pl(4'b0001, 0, 0, 1);
        st(sv(1, 1, 1, 0, 0, 0, 0, 1));
        for (int k = 1; k < n; k++) pl(4'b0010, 0);
        st(sv(0, 1, 1, 0, 1, 0, 0, 1));
        pl(4'b0010, 0);
        st(sv(0, 1, 1, 0, 0, 0, 0, 0));
        $display("test receive flags done");
        apb(1'b1, ULS_OFF_CTRL, ctl(0, 1, 4'h4));
        pl(4'b0001, 0);
        pl(4'b0001, 0);
        `CHK(rx_full, 1'b1)
        st(sv(0, 1, 1, 0, 0, 0, 1, 1));
        st(sv(0, 1, 1, 0, 0, 0, 0, 1));
        pl(4'b0010, 0);
        $display("test overrun done");
        apb(1'b1, ULS_OFF_CTRL, ctl(1, 0, 4'h4));
        @(posedge pclk) rx_line <= 1'b0;
        rx_bit_tick <= 1'b1;
        repeat (12) @(posedge pclk);
        rx_line <= 1'b1;
        @(posedge pclk) rx_bit_tick <= 1'b0;
        st(sv(1, 1, 1, 1, 0, 0, 0, 1));
        `CHK(tx_irq, 1'b0)
        pl(4'b0010, 0);
        st(sv(0, 1, 1, 0, 0, 0, 0, 0));
        $display("test break done");
        stop_test();
    end
endmodule : uls_line_status_tb
